// ==== common/hdi_defs.svh ====
// constants of the host datagram interface
`ifndef HDI_DEFS_SVH
`define HDI_DEFS_SVH
`define HDI_HDR_LAST 6'd7
`define HDI_FRAME_LAST 6'd31
`define HDI_OUT_TOP 5'd31
`define HDI_OUT_LAST 5'd0
`define HDI_NUM_REGS 7'd64
`define HDI_REG_RESET 24'h000000
`define HDI_IDX_TARGET 4'h0
`define HDI_IDX_ACTUAL 4'h1
`define HDI_IDX_REFCONF 4'hA
`define HDI_REF_INV_BIT 0
`define HDI_REF_EN_BIT 1
`define HDI_R_FIRST_COMMON 6'h30
`define HDI_R_DGRAM_LO 6'h30
`define HDI_R_DGRAM_HI 6'h31
`define HDI_R_COVER_CFG 6'h32
`define HDI_R_COVER_DATA 6'h33
`define HDI_R_SWITCH_RAW 6'h3E
`define HDI_R_GLOBAL 6'h3F
`define HDI_COVER_LEN_LSB 0
`define HDI_COVER_POS_LSB 8
`define HDI_COVER_MAX 24
`define HDI_CHAIN_BITS 48
`define HDI_AHB_CTRL 12'h000
`define HDI_AHB_STATUS 12'h004
`define HDI_AHB_DRV_LO 12'h008
`define HDI_AHB_DRV_HI 12'h00C
`define HDI_CTRL_CONT_BIT 0
`endif

// ==== common/hdi_pkg.sv ====
// types of the host datagram interface
package hdi_pkg;
  typedef struct packed {
    logic select_n;
    logic sclk;
    logic sdi;
  } hdi_link_t;
  typedef struct packed {
    logic irq_low_flag;
    logic overlay_pending;
    logic ref_state_3;
    logic at_target_3;
    logic ref_state_2;
    logic at_target_2;
    logic ref_state_1;
    logic at_target_1;
  } hdi_status_t;
endpackage

// ==== rtl/hdi_top.sv ====
// serial datagram decoder, register and RAM store, overlay handling
//
// The implementer's own choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`include "hdi_defs.svh"
module hdi_top #(
  parameter int PERIOD = 1000
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire hdi_pkg::hdi_link_t host_link,
  input wire logic switch_input_1,
  input wire logic switch_input_2,
  input wire logic switch_input_3,
  output logic host_serial_out,
  output logic drv_valid,
  output logic [47:0] drv_data
);
  logic [23:0] regs [0:63];
  logic [5:0] ram [0:127];
  logic [2:0] sel_s, sclk_s;
  logic [1:0] sdi_s;
  logic [2:0] sw_s1, sw_s2;
  logic [5:0] bitcnt;
  logic [30:0] in_shift;
  logic [6:0] hdr_addr;
  logic hdr_rw;
  logic [31:0] rep;
  logic [4:0] outidx;
  logic init_busy;
  logic [6:0] init_idx;
  logic overlay_pending;
  logic send_pending;
  logic continuous;
  logic [15:0] period_cnt;
  logic irq_low_flag;
  logic [2:0] at_target, ref_state;
  logic ap_valid, ap_write;
  logic [11:0] ap_addr;
  logic rise, fall, sel_fall, selected, hdr_done, frame_done;
  logic [7:0] header;
  logic [31:0] word_in;
  logic [23:0] rd_data;
  logic reg_wr, ram_wr, period_tick, send_now;
  logic [47:0] frame;
  hdi_pkg::hdi_status_t status;

  // link pins sampled twice before use; stage 0 feeds only stage 1
  always_ff @(posedge clock)
  begin
    sel_s <= {sel_s[1:0], host_link.select_n};
    sclk_s <= {sclk_s[1:0], host_link.sclk};
    sdi_s <= {sdi_s[0], host_link.sdi};
    sw_s1 <= {switch_input_3, switch_input_2, switch_input_1};
    sw_s2 <= sw_s1;
  end

  assign selected = ~sel_s[1];
  assign sel_fall = ~sel_s[1] & sel_s[2];
  assign rise = sclk_s[1] & ~sclk_s[2] & selected;
  assign fall = ~sclk_s[1] & sclk_s[2] & selected;
  assign header = {in_shift[6:0], sdi_s[1]};
  assign word_in = {in_shift, sdi_s[1]};
  assign hdr_done = rise && bitcnt == `HDI_HDR_LAST;
  assign frame_done = rise && bitcnt == `HDI_FRAME_LAST;
  assign reg_wr = frame_done && !hdr_rw && !hdr_addr[6] && !init_busy;
  assign ram_wr = frame_done && !hdr_rw && hdr_addr[6];

  // shift in, MSB first
  always_ff @(posedge clock)
  begin
    if (!rst_n || sel_fall)
      bitcnt <= 6'h00;
    else if (rise)
      bitcnt <= bitcnt + 6'h01;
    if (rise)
      in_shift <= word_in[30:0];
    if (!rst_n)
    begin
      hdr_addr <= 7'h00;
      hdr_rw <= 1'b0;
    end
    else if (hdr_done)
    begin
      hdr_addr <= header[7:1];
      hdr_rw <= header[0];
    end
  end

  // read mux: register block, or a pair of 6-bit RAM words
  always_comb
  begin
    rd_data = 24'h000000;
    if (header[7])
      rd_data = {12'h000, ram[{header[6:1], 1'b1}], ram[{header[6:1], 1'b0}]};
    else if (header[6:1] == `HDI_R_SWITCH_RAW)
      rd_data = {21'h0, sw_s2};
    else
      rd_data = regs[header[6:1]];
  end

  // reply: status at select fall, read data once the header is in
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      rep <= 32'h00000000;
      outidx <= `HDI_OUT_TOP;
    end
    else if (sel_fall)
    begin
      rep <= {status, 24'h000000};
      outidx <= `HDI_OUT_TOP;
    end
    else
    begin
      if (hdr_done)
        rep[23:0] <= rd_data;
      if (fall && outidx != `HDI_OUT_LAST)
        outidx <= outidx - 5'd1;
    end
  end

  // idle select shows the interrupt, a transfer shows reply bits
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      host_serial_out <= 1'b1;
    else if (sel_s[1])
      host_serial_out <= irq_low_flag;
    else
      host_serial_out <= rep[outidx];
  end

  // power-up clearing, one register per cycle
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      init_busy <= 1'b1;
      init_idx <= 7'h00;
    end
    else if (init_busy)
    begin
      init_idx <= init_idx + 7'h01;
      init_busy <= (init_idx + 7'h01) != `HDI_NUM_REGS;
    end
  end

  // read-only switch word ignores writes; cover data write also triggers
  always_ff @(posedge clock)
  begin
    if (init_busy)
      regs[init_idx[5:0]] <= `HDI_REG_RESET;
    else if (reg_wr && hdr_addr[5:0] != `HDI_R_SWITCH_RAW)
      regs[hdr_addr[5:0]] <= word_in[23:0];
  end

  // RAM is left uninitialised; the host must fill it first
  always_ff @(posedge clock)
  begin
    if (ram_wr)
    begin
      ram[{hdr_addr[5:0], 1'b0}] <= word_in[5:0];
      ram[{hdr_addr[5:0], 1'b1}] <= word_in[11:6];
    end
  end

  // status conditions
  always_ff @(posedge clock)
  begin
    for (int m = 0; m < 3; m++)
    begin
      at_target[m] <= regs[6'(m * 16) + {2'b00, `HDI_IDX_TARGET}]
        == regs[6'(m * 16) + {2'b00, `HDI_IDX_ACTUAL}];
      ref_state[m] <= regs[6'(m * 16) + {2'b00, `HDI_IDX_REFCONF}][`HDI_REF_EN_BIT]
        & (sw_s2[m] ^ regs[6'(m * 16) + {2'b00, `HDI_IDX_REFCONF}][`HDI_REF_INV_BIT]);
    end
    if (!rst_n || init_busy)
      irq_low_flag <= 1'b1;
    else
      irq_low_flag <= ~|({ref_state[2], at_target[2], ref_state[1], at_target[1],
        ref_state[0], at_target[0]} & regs[`HDI_R_GLOBAL][5:0]);
  end

  assign status = {irq_low_flag, overlay_pending, ref_state[2], at_target[2],
    ref_state[1], at_target[1], ref_state[0], at_target[0]};

  // overlay replaces the bits of the two datagram words at the set position, for one send only
  always_comb
  begin
    int pos;
    int len;
    pos = int'(regs[`HDI_R_COVER_CFG][`HDI_COVER_POS_LSB +: 6]);
    len = int'(regs[`HDI_R_COVER_CFG][`HDI_COVER_LEN_LSB +: 5]);
    frame = {regs[`HDI_R_DGRAM_HI], regs[`HDI_R_DGRAM_LO]};
    if (overlay_pending)
      for (int i = 0; i < `HDI_CHAIN_BITS; i++)
        if (i >= pos && i < pos + len && i - pos < `HDI_COVER_MAX)
          frame[i] = regs[`HDI_R_COVER_DATA][i - pos];
  end

  assign period_tick = continuous && period_cnt == 16'(PERIOD - 1);
  assign send_now = !init_busy && (send_pending || overlay_pending || period_tick);

  always_ff @(posedge clock)
  begin
    if (!rst_n || !continuous || period_tick)
      period_cnt <= 16'h0000;
    else
      period_cnt <= period_cnt + 16'h0001;
  end

  // a new write that lands while sending stays pending
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      send_pending <= 1'b0;
      overlay_pending <= 1'b0;
    end
    else
    begin
      send_pending <= (reg_wr && hdr_addr[5:0] < `HDI_R_FIRST_COMMON)
        || (send_pending && !send_now);
      overlay_pending <= (reg_wr && hdr_addr[5:0] == `HDI_R_COVER_DATA)
        || (overlay_pending && !send_now);
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      drv_valid <= 1'b0;
      drv_data <= 48'h000000000000;
    end
    else
    begin
      drv_valid <= send_now;
      if (send_now)
        drv_data <= frame;
    end
  end

  // AHB-Lite slave, zero wait states, always OKAY
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr <= 12'h000;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      ap_valid <= hsel && htrans[1] && hready;
      ap_write <= hwrite;
      ap_addr <= haddr[11:0];
      if (hsel && htrans[1] && hready && !hwrite)
        unique case (haddr[11:0])
          `HDI_AHB_CTRL: hrdata <= {31'h0, continuous};
          `HDI_AHB_STATUS: hrdata <= {23'h0, init_busy, status};
          `HDI_AHB_DRV_LO: hrdata <= {8'h00, drv_data[23:0]};
          `HDI_AHB_DRV_HI: hrdata <= {8'h00, drv_data[47:24]};
          default: hrdata <= 32'h00000000;
        endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      continuous <= 1'b0;
    else if (ap_valid && ap_write && ap_addr == `HDI_AHB_CTRL)
      continuous <= hwdata[`HDI_CTRL_CONT_BIT];
  end

  sequence s_sel_fall;
    sel_fall;
  endsequence
  sequence s_hdr_read;
    hdr_done && header[0];
  endsequence

  AST_IDLE_IRQ: assert property (@(posedge clock) disable iff (!rst_n)
    sel_s[1] |=> host_serial_out == $past(irq_low_flag))
    else $error("idle output does not show interrupt");
  AST_STATUS_LOAD: assert property (@(posedge clock) disable iff (!rst_n)
    s_sel_fall |=> rep[31:24] == $past(status))
    else $error("status byte not loaded at select fall");
  AST_READ_DATA: assert property (@(posedge clock) disable iff (!rst_n)
    s_hdr_read |=> rep[23:0] == $past(rd_data) && rep[31:24] == $past(rep[31:24]))
    else $error("read data not placed in low bits");
  AST_AT_TARGET: assert property (@(posedge clock) disable iff (!rst_n || init_busy)
    ##1 at_target[0] == ($past(regs[0]) == $past(regs[1])))
    else $error("at target bit wrong");
  AST_OVERLAY_SET: assert property (@(posedge clock) disable iff (!rst_n)
    reg_wr && hdr_addr[5:0] == `HDI_R_COVER_DATA |=> overlay_pending ##1 drv_valid)
    else $error("overlay not pending or not sent");
  AST_NO_SEND_INIT: assert property (@(posedge clock) disable iff (!rst_n)
    init_busy && $past(init_busy) |-> !drv_valid)
    else $error("chain datagram sent during init");
  AST_IRQ: assert property (@(posedge clock) disable iff (!rst_n || init_busy)
    |({ref_state[2], at_target[2], ref_state[1], at_target[1], ref_state[0],
      at_target[0]} & regs[`HDI_R_GLOBAL][5:0]) |=> !irq_low_flag)
    else $error("interrupt not raised");
  AST_RAM_PAIR: assert property (@(posedge clock) disable iff (!rst_n)
    ram_wr |=> ram[{$past(hdr_addr[5:0]), 1'b1}] == $past(word_in[11:6]))
    else $error("odd RAM word wrong");
  AST_ON_DEMAND: assert property (@(posedge clock) disable iff (!rst_n)
    !continuous && !send_pending && !overlay_pending |=> !drv_valid)
    else $error("chain datagram without demand");
endmodule

// ==== tb/hdi_host_model.sv ====
// host microcontroller model driving the serial datagram link
`timescale 1ns/1ps
module hdi_host_model (
  output hdi_pkg::hdi_link_t link,
  input wire logic sdo,
  output logic irq_n
);
  initial link = '{select_n: 1'h1, sclk: 1'h0, sdi: 1'h0};
  // output toggles during a frame, so the interrupt is only looked at while idle
  always @(sdo or link.select_n)
    if (link.select_n)
      irq_n = sdo;
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    #3 link.select_n = 1'h0;
    for (int i = 31; i >= 0; i--)
    begin
      link.sdi = tx[i];
      #80 link.sclk = 1'h1;
      rx[i] = sdo;
      #80 link.sclk = 1'h0;
    end
    #80 link.select_n = 1'h1;
    // released data line must not keep the last bit
    link.sdi = ~link.sdi;
    #80;
  endtask
endmodule

// ==== tb/testbench.sv ====
// self-checking bench of the host datagram interface
`timescale 1ns/1ps
module testbench;
  logic clock = 1'h0;
  logic rst_n = 1'h0;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, sout, drv_valid, irq_n;
  logic [47:0] drv_data, last_drv;
  logic [2:0] sw_pins = 3'h0;
  hdi_pkg::hdi_link_t link;
  int errors = 0;
  int cmp_count = 0;
  int npulse = 0;
  logic [23:0] tgt [3];
  logic [23:0] act [3];
  logic [1:0] rcf [3];
  logic [5:0] msk;
  always #5 clock = ~clock;
  // short send period keeps the continuous-send test brief
  hdi_top #(.PERIOD(8)) dut_u (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .host_link(link),
    .switch_input_1(sw_pins[0]), .switch_input_2(sw_pins[1]), .switch_input_3(sw_pins[2]),
    .host_serial_out(sout), .drv_valid(drv_valid), .drv_data(drv_data));
  hdi_host_model host_u (.link(link), .sdo(sout), .irq_n(irq_n));
  always @(posedge clock)
    if (drv_valid === 1'h1)
    begin
      npulse++;
      last_drv = drv_data;
    end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] st();
    logic [5:0] c;
    for (int k = 0; k < 3; k++)
      c[2*k +: 2] = {rcf[k][1] & (sw_pins[k] ^ rcf[k][0]), tgt[k] == act[k]};
    return {~|(c & msk), 1'h0, c};
  endfunction
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] r);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'h1);
    r = hrdata;
  endtask
  task automatic ser(input logic [6:0] a, input logic rd, input logic [23:0] d,
    output logic [31:0] rx);
    host_u.xfer({a, rd, d}, rx);
    @(posedge clock);
  endtask
  task automatic wr_rd(input logic [6:0] a, input logic [23:0] d, input logic [23:0] e);
    logic [31:0] rx;
    ser(a, 1'h0, d, rx);
    ser(a, 1'h1, 24'h0, rx);
    chk(rx, {st(), e});
  endtask
  initial
  begin
    // about a hundred serial frames of roughly 5.3 us each, with margin
    #800000;
    errors++;
    finish_test();
  end
  initial
  begin
    logic [31:0] rx, r0;
    logic [23:0] d, w0, w1;
    logic [47:0] e, m;
    int n0, len, pos;
    void'($urandom(32'h7041D53B));
    for (int k = 0; k < 3; k++)
    begin
      tgt[k] = 24'h0;
      act[k] = 24'h0;
      rcf[k] = 2'h0;
    end
    msk = 6'h0;
    repeat (3) @(posedge clock);
    rst_n <= 1'h1;
    n0 = npulse;
    @(posedge clock);
    ahb(1'h0, 32'h4, 32'h0, rx);
    chk(rx[8], 1'h1);
    repeat (70) @(posedge clock);
    chk(npulse - n0, 0);
    ahb(1'h0, 32'h4, 32'h0, rx);
    chk(rx, 32'h95);
    $display("test init done");
    // the RAM must be filled before any target parameter is written
    for (int i = 0; i < 64; i++)
      ser({1'h1, 6'(i)}, 1'h0, 24'(i), rx);
    ser(7'h45, 1'h1, 24'h0, rx);
    chk(rx, {st(), 24'h5});
    $display("test ram init done");
    for (int k = 0; k < 3; k++)
    begin
      n0 = npulse;
      tgt[k] = 24'($urandom);
      wr_rd({1'h0, k[1:0], 4'h0}, tgt[k], tgt[k]);
      chk(npulse - n0, 1);
    end
    act[0] = tgt[0];
    wr_rd(7'h01, act[0], act[0]);
    $display("test registers done");
    repeat (4)
    begin
      rx[6:0] = 7'h40 + 7'($urandom_range(63));
      d = 24'($urandom_range(4095));
      wr_rd(rx[6:0], d, d);
    end
    ser(7'h3E, 1'h1, 24'h0, r0);
    chk(r0, {st(), 21'h0, sw_pins});
    ser(7'h3E, 1'h0, ~r0[23:0], rx);
    ser(7'h3E, 1'h1, 24'h0, rx);
    chk(rx, {st(), 21'h0, sw_pins});
    $display("test ram done");
    repeat (3)
    begin
      for (int k = 0; k < 3; k++)
      begin
        rcf[k] = 2'($urandom);
        ser({1'h0, k[1:0], 4'hA}, 1'h0, {22'h0, rcf[k]}, rx);
      end
      sw_pins <= 3'($urandom);
      msk = 6'($urandom);
      wr_rd(7'h3F, {18'h0, msk}, {18'h0, msk});
      e[7:0] = st();
      chk(irq_n, e[7]);
    end
    $display("test status done");
    w0 = 24'($urandom);
    w1 = 24'($urandom);
    ser(7'h30, 1'h0, w0, rx);
    ser(7'h31, 1'h0, w1, rx);
    len = $urandom_range(24, 1);
    pos = $urandom_range(48 - len);
    ser(7'h32, 1'h0, 24'(pos * 256 + len), rx);
    n0 = npulse;
    d = 24'($urandom);
    ser(7'h33, 1'h0, d, rx);
    m = ((48'h1 << len) - 48'h1) << pos;
    e = ({w1, w0} & ~m) | ((48'(d) << pos) & m);
    chk(npulse - n0, 1);
    chk(last_drv, e);
    ahb(1'h0, 32'h8, 32'h0, rx);
    ahb(1'h0, 32'hC, 32'h0, r0);
    chk({r0[23:0], rx[23:0]}, e);
    ser(7'h3F, 1'h1, 24'h0, rx);
    chk(rx[30], 1'h0);
    $display("test overlay done");
    ahb(1'h1, 32'h0, 32'h1, rx);
    ahb(1'h0, 32'h0, 32'h0, rx);
    chk(rx, 32'h1);
    n0 = npulse;
    repeat (80) @(posedge clock);
    chk((npulse - n0) inside {[9:11]}, 1'h1);
    ahb(1'h1, 32'h0, 32'h0, rx);
    repeat (10) @(posedge clock);
    n0 = npulse;
    repeat (80) @(posedge clock);
    chk(npulse - n0, 0);
    ahb(1'h0, 32'h10, 32'h0, rx);
    chk({hreadyout, hresp, rx}, 34'h200000000);
    $display("test chain done");
    finish_test();
  end
endmodule
